// [logic/storage_security_lock_fsm.sv]
// Security lock state machine of the storage command layer.
`timescale 1ns/1ns
`default_nettype none
`include "sec_lock_defines.svh"
module storage_security_lock_fsm (
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    input  wire logic [4:0]  addr_in,
    input  wire logic [15:0] wr_data_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    input  wire logic        factory_init_in,
    output logic      [15:0] rd_data_out,
    output logic             cmd_done_out,
    output logic             err_out,
    output logic             command_aborted_flag_out,
    output logic             exec_out,
    output logic      [7:0]  exec_code_out,
    output logic             erase_media_out,
    output logic             locked_out,
    output logic             frozen_out,
    output logic             attempts_exhausted_flag_out
);
    import sec_lock_pkg::*;

    sec_state_t  s;
    sec_state_t  next_s;
    logic        mem_we;
    logic [5:0]  mem_waddr;
    logic [15:0] mem_wdata;
    logic [5:0]  mem_raddr_a;
    logic [5:0]  mem_raddr_b;
    logic [15:0] mem_rdata_a;
    logic [15:0] mem_rdata_b;
    logic [1:0]  target_bank;
    logic        cmd_wr;

    function automatic logic is_media(input logic [7:0] c);
        case (c)
            8'h20, 8'h21, 8'h22, 8'h23, 8'h40, 8'h41, 8'hc4,
            8'h30, 8'h31, 8'h32, 8'h33, 8'h3c, 8'hc5, 8'h38, 8'hcd,
            8'hc0, 8'h50: is_media = 1'b1;
            default:      is_media = 1'b0;
        endcase
    endfunction

    // Gating applied before a command does anything at all.
    function automatic logic refused(input sec_state_t x, input logic [7:0] c);
        logic r;
        r = 1'b0;
        if (x.locked && (is_media(c) || c == `CMD_DISABLE_PWD || c == `CMD_FREEZE
                || c == `CMD_SET_PWD)) begin
            r = 1'b1;
        end
        if (x.frozen && (c == `CMD_SET_PWD || c == `CMD_DISABLE_PWD
                || c == `CMD_ERASE_UNIT || c == `CMD_UNLOCK)) begin
            r = 1'b1;
        end
        if (x.exhausted && (c == `CMD_UNLOCK || c == `CMD_ERASE_UNIT)) begin
            r = 1'b1;
        end
        refused = r;
    endfunction

    function automatic sec_state_t finish(input sec_state_t x, input logic abort);
        sec_state_t y;
        y = x;
        y.done = 1'b1;
        y.err = abort;
        y.aborted = abort;
        y.st = ST_IDLE;
        finish = y;
    endfunction

    assign target_bank = s.ident_master ? `BANK_MASTER : `BANK_USER;
    assign cmd_wr = wr_in && (addr_in == `REG_CMD) && (s.st == ST_IDLE);

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.exec = 1'b0;
        next_s.erase_pulse = 1'b0;
        next_s.rd_data = 16'h0000;
        mem_we = 1'b0;
        mem_waddr = 6'h00;
        mem_wdata = 16'h0000;
        mem_raddr_a = {`BANK_STAGE, s.idx};
        mem_raddr_b = {target_bank, s.idx};
        next_s.exhausted = (s.counter == 3'h0);
        if (rd_in) begin
            case (addr_in)
                `REG_STATUS: begin
                    next_s.rd_data = {5'h00, s.counter, 2'h0, s.level_max, s.enabled,
                        s.frozen, s.locked, s.err, s.st != ST_IDLE};
                end
                `REG_ERROR: begin
                    next_s.rd_data[`ERR_ABORT_BIT] = s.aborted;
                end
                `REG_IDENT128: begin
                    next_s.rd_data[`ID_SUPPORTED_BIT] = 1'b1;
                    next_s.rd_data[`ID_ENABLED_BIT] = s.enabled;
                    next_s.rd_data[`ID_LOCKED_BIT] = s.locked;
                    next_s.rd_data[`ID_FROZEN_BIT] = s.frozen;
                    next_s.rd_data[`ID_EXHAUSTED_BIT] = s.exhausted;
                    next_s.rd_data[`ID_MAXLVL_BIT] = s.level_max;
                end
                default: begin
                    next_s.rd_data = 16'h0000;
                end
            endcase
        end
        case (s.st)
            ST_BOOT: begin
                mem_raddr_a = `FLAG_ADDR;
                next_s.st = ST_BOOT_LD;
            end
            ST_BOOT_LD: begin
                next_s.enabled = mem_rdata_a[0];
                next_s.level_max = mem_rdata_a[1];
                next_s.locked = mem_rdata_a[0];
                next_s.st = ST_IDLE;
            end
            ST_IDLE: begin
                if (wr_in && addr_in <= `REG_PWD_LAST) begin
                    mem_we = 1'b1;
                    mem_waddr = {`BANK_STAGE, addr_in[3:0]};
                    mem_wdata = wr_data_in;
                end
                if (wr_in && addr_in == `REG_CTRL) begin
                    next_s.ident_master = wr_data_in[`CTRL_MASTER_BIT];
                    next_s.level_req = wr_data_in[`CTRL_MAXLVL_BIT];
                end
                if (factory_init_in) begin
                    next_s.idx = 4'h0;
                    next_s.st = ST_FACTORY;
                end else if (cmd_wr) begin
                    next_s.cmd = wr_data_in[7:0];
                    next_s.idx = 4'h0;
                    next_s.mismatch = 1'b0;
                    next_s.erase_prep = (wr_data_in[7:0] == `CMD_ERASE_PREP);
                    if (refused(s, wr_data_in[7:0])) begin
                        next_s = finish(next_s, 1'b1);
                    end else begin
                        case (wr_data_in[7:0])
                            `CMD_SET_PWD:    next_s.st = ST_COPY_RD;
                            `CMD_UNLOCK:     next_s.st = ST_CMP_RD;
                            `CMD_DISABLE_PWD: next_s.st = ST_CMP_RD;
                            `CMD_ERASE_UNIT: begin
                                if (s.erase_prep) begin
                                    next_s.st = ST_CMP_RD;
                                end else begin
                                    next_s = finish(next_s, 1'b1);
                                end
                            end
                            `CMD_ERASE_PREP: next_s = finish(next_s, 1'b0);
                            `CMD_FREEZE: begin
                                next_s.frozen = 1'b1;
                                next_s = finish(next_s, 1'b0);
                            end
                            default: begin
                                next_s.exec = 1'b1;
                                next_s.exec_code = wr_data_in[7:0];
                                next_s = finish(next_s, 1'b0);
                            end
                        endcase
                    end
                end
            end
            ST_CMP_RD: begin
                next_s.st = ST_CMP_CHK;
            end
            ST_CMP_CHK: begin
                if (mem_rdata_a != mem_rdata_b) begin
                    next_s.mismatch = 1'b1;
                end
                if (s.idx == `LAST_WORD) begin
                    next_s.st = ST_DECIDE;
                end else begin
                    next_s.idx = s.idx + 4'h1;
                    next_s.st = ST_CMP_RD;
                end
            end
            ST_DECIDE: begin
                case (s.cmd)
                    `CMD_UNLOCK: begin
                        // The master password is never good enough to unlock at maximum level; erase unit still takes it.
                        if (s.mismatch || (s.ident_master && s.level_max)) begin
                            if (s.counter != 3'h0) begin
                                next_s.counter = s.counter - 3'h1;
                            end
                            next_s = finish(next_s, 1'b1);
                        end else begin
                            next_s.locked = 1'b0;
                            next_s = finish(next_s, 1'b0);
                        end
                    end
                    `CMD_ERASE_UNIT: begin
                        if (s.mismatch) begin
                            next_s = finish(next_s, 1'b1);
                        end else begin
                            next_s.locked = 1'b0;
                            next_s.enabled = 1'b0;
                            next_s.erase_pulse = 1'b1;
                            next_s.st = ST_FLAGS;
                        end
                    end
                    default: begin
                        if (s.mismatch || (s.ident_master && s.level_max)) begin
                            next_s = finish(next_s, 1'b1);
                        end else begin
                            next_s.enabled = 1'b0;
                            next_s.st = ST_FLAGS;
                        end
                    end
                endcase
            end
            ST_COPY_RD: begin
                next_s.st = ST_COPY_WR;
            end
            ST_COPY_WR: begin
                mem_we = 1'b1;
                mem_waddr = {target_bank, s.idx};
                mem_wdata = mem_rdata_a;
                if (s.idx != `LAST_WORD) begin
                    next_s.idx = s.idx + 4'h1;
                    next_s.st = ST_COPY_RD;
                end else if (s.ident_master) begin
                    next_s = finish(next_s, 1'b0);
                end else begin
                    next_s.enabled = 1'b1;
                    next_s.level_max = s.level_req;
                    next_s.st = ST_FLAGS;
                end
            end
            ST_FLAGS: begin
                mem_we = 1'b1;
                mem_waddr = `FLAG_ADDR;
                mem_wdata = {14'h0000, s.level_max, s.enabled};
                next_s = finish(next_s, 1'b0);
            end
            ST_FACTORY: begin
                mem_we = 1'b1;
                mem_waddr = {`BANK_MASTER, s.idx};
                mem_wdata = `MASTER_DEFAULT;
                if (s.idx == `LAST_WORD) begin
                    next_s.enabled = 1'b0;
                    next_s.level_max = 1'b0;
                    next_s.locked = 1'b0;
                    next_s.st = ST_FLAGS;
                end else begin
                    next_s.idx = s.idx + 4'h1;
                end
            end
            default: begin
                next_s.st = ST_IDLE;
            end
        endcase
    end

    // Frozen only clears here: the single reset stands for power removal as well.
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            s <= '0;
            s.st <= ST_BOOT;
            s.counter <= `ATTEMPTS_INIT;
            s.exhausted <= 1'b0;
            s.frozen <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    pwd_store u_store (
        .clk_in      (clk_in),
        .we_in       (mem_we),
        .waddr_in    (mem_waddr),
        .wdata_in    (mem_wdata),
        .raddr_a_in  (mem_raddr_a),
        .raddr_b_in  (mem_raddr_b),
        .rdata_a_out (mem_rdata_a),
        .rdata_b_out (mem_rdata_b)
    );

    assign rd_data_out = s.rd_data;
    assign cmd_done_out = s.done;
    assign err_out = s.err;
    assign command_aborted_flag_out = s.aborted;
    assign exec_out = s.exec;
    assign exec_code_out = s.exec_code;
    assign erase_media_out = s.erase_pulse;
    assign locked_out = s.locked;
    assign frozen_out = s.frozen;
    assign attempts_exhausted_flag_out = s.exhausted;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    sequence cmd_issue(logic [7:0] c);
        cmd_wr && !factory_init_in && wr_data_in[7:0] == c;
    endsequence

    a_locked_media_refused: assert property (
        (cmd_wr && !factory_init_in && s.locked && is_media(wr_data_in[7:0]))
        |=> cmd_done_out && command_aborted_flag_out && err_out && !exec_out)
        else $error("media command ran while locked");
    a_frozen_blocks_set: assert property (
        (cmd_issue(`CMD_SET_PWD) and s.frozen) |=> cmd_done_out && command_aborted_flag_out)
        else $error("set password accepted while frozen");
    a_freeze_enters_frozen: assert property (
        (cmd_issue(`CMD_FREEZE) and !s.locked) |=> frozen_out && !command_aborted_flag_out)
        else $error("freeze lock did not freeze");
    a_frozen_stays: assert property (
        frozen_out |=> frozen_out)
        else $error("frozen state left without reset");
    a_exhausted_aborts: assert property (
        (cmd_issue(`CMD_UNLOCK) and attempts_exhausted_flag_out)
        |=> cmd_done_out && command_aborted_flag_out ##1 locked_out == $past(locked_out))
        else $error("unlock not aborted after attempts ran out");
    a_boot_counter_five: assert property (
        s.st == ST_BOOT |-> s.counter == 3'h5 && !attempts_exhausted_flag_out)
        else $error("attempt counter not reloaded by reset");
    a_fail_decrements: assert property (
        (s.st == ST_DECIDE && s.cmd == `CMD_UNLOCK && s.mismatch && s.counter != 3'h0)
        |=> s.counter == $past(s.counter) - 3'h1 && command_aborted_flag_out)
        else $error("failed unlock did not decrement counter");
    a_master_max_denied: assert property (
        (s.st == ST_DECIDE && s.cmd == `CMD_UNLOCK && s.ident_master && s.level_max)
        |=> command_aborted_flag_out && locked_out == $past(locked_out))
        else $error("master password unlocked at maximum level");
    a_erase_unlocks: assert property (
        (s.st == ST_DECIDE && s.cmd == `CMD_ERASE_UNIT && !s.mismatch)
        |=> erase_media_out && !locked_out ##1 cmd_done_out && !err_out)
        else $error("erase unit with matching password failed");
    a_boot_locks: assert property (
        (s.st == ST_BOOT_LD && mem_rdata_a[0]) |=> locked_out)
        else $error("enabled device came up unlocked");
endmodule
`default_nettype wire

// [logic/sec_lock_defines.svh]
// Register offsets, field positions, command codes and reset values of the security lock.
`ifndef SEC_LOCK_DEFINES_SVH
`define SEC_LOCK_DEFINES_SVH

`define REG_PWD_LAST      5'h0f
`define REG_CTRL          5'h10
`define REG_CMD           5'h11
`define REG_STATUS        5'h12
`define REG_ERROR         5'h13
`define REG_IDENT128      5'h14

`define CTRL_MASTER_BIT   0
`define CTRL_MAXLVL_BIT   1
`define ERR_ABORT_BIT     2
`define ID_SUPPORTED_BIT  0
`define ID_ENABLED_BIT    1
`define ID_LOCKED_BIT     2
`define ID_FROZEN_BIT     3
`define ID_EXHAUSTED_BIT  4
`define ID_MAXLVL_BIT     8

`define BANK_STAGE        2'h0
`define BANK_USER         2'h1
`define BANK_MASTER       2'h2
`define FLAG_ADDR         6'h30
`define LAST_WORD         4'hf

`define ATTEMPTS_INIT     3'h5
`define MASTER_DEFAULT    16'h5a3c

`define CMD_SET_PWD       8'hf1
`define CMD_UNLOCK        8'hf2
`define CMD_ERASE_PREP    8'hf3
`define CMD_ERASE_UNIT    8'hf4
`define CMD_FREEZE        8'hf5
`define CMD_DISABLE_PWD   8'hf6

`endif

// [logic/sec_lock_pkg.sv]
// Types shared by the security lock controller and its password store.
package sec_lock_pkg;

    typedef enum logic [3:0] {
        ST_BOOT, ST_BOOT_LD, ST_IDLE, ST_CMP_RD, ST_CMP_CHK, ST_DECIDE,
        ST_COPY_RD, ST_COPY_WR, ST_FLAGS, ST_FACTORY
    } sec_fsm_t;

    typedef struct packed {
        sec_fsm_t    st;
        logic [3:0]  idx;
        logic [7:0]  cmd;
        logic        ident_master;
        logic        level_req;
        logic        mismatch;
        logic        locked;
        logic        frozen;
        logic        enabled;
        logic        level_max;
        logic [2:0]  counter;
        logic        exhausted;
        logic        erase_prep;
        logic        err;
        logic        aborted;
        logic [15:0] rd_data;
        logic        done;
        logic        exec;
        logic [7:0]  exec_code;
        logic        erase_pulse;
    } sec_state_t;

    typedef struct packed {
        logic [63:0][15:0] words;
        logic [15:0]       rdata_a;
        logic [15:0]       rdata_b;
    } mem_state_t;

endpackage

// [logic/pwd_store.sv]
// Password store: staging, user, master and flag words, two registered read ports.
`timescale 1ns/1ns
`default_nettype none
module pwd_store (
    input  wire logic        clk_in,
    input  wire logic        we_in,
    input  wire logic [5:0]  waddr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic [5:0]  raddr_a_in,
    input  wire logic [5:0]  raddr_b_in,
    output logic      [15:0] rdata_a_out,
    output logic      [15:0] rdata_b_out
);
    import sec_lock_pkg::*;

    // No reset on purpose: this array stands for non-volatile storage that must
    // survive a hardware reset, so the stored passwords and lock flags persist.
    mem_state_t s;
    mem_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.rdata_a = s.words[raddr_a_in];
        next_s.rdata_b = s.words[raddr_b_in];
        if (we_in) begin
            next_s.words[waddr_in] = wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        s <= next_s;
    end

    assign rdata_a_out = s.rdata_a;
    assign rdata_b_out = s.rdata_b;
endmodule
`default_nettype wire

// [dv/host_bus.sv]
// Host bus master model that issues register accesses and security commands.
`timescale 1ns/1ns
`default_nettype none
`include "sec_lock_defines.svh"
module host_bus (
    input  wire logic        clk_in,
    input  wire logic [15:0] rd_data_in,
    output logic      [4:0]  addr_out,
    output logic      [15:0] wr_data_out,
    output logic             wr_out,
    output logic             rd_out
);
    initial begin
        addr_out = 5'h00;
        wr_data_out = 16'h0000;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    // Released lines show the inverse, so a stale value never passes for a live one.
    task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_out <= a;
        wr_data_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
        addr_out <= ~a;
        wr_data_out <= ~d;
    endtask
    task automatic read_reg(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        @(posedge clk_in);
        d = rd_data_in;
    endtask
    // A careful host freezes the lock once passwords are settled.
    task automatic freeze_lock;
        write_reg(`REG_CMD, {8'h00, `CMD_FREEZE});
    endtask
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench: a host model drives the lock, a behavioural model predicts it.
`timescale 1ns/1ns
`default_nettype none
`include "sec_lock_defines.svh"
module tb_top;
    logic              clk_in = 1'b0;
    logic              reset_in = 1'b1;
    logic              factory_init_in = 1'b0;
    logic [4:0]        addr;
    logic [15:0]       wr_data;
    logic              wr;
    logic              rd;
    logic [15:0]       rd_data;
    logic              cmd_done;
    logic              err;
    logic              aborted;
    logic              exec;
    logic [7:0]        exec_code;
    logic              erase;
    logic              locked;
    logic              frozen;
    logic              exhausted;
    int                err_total = 0;
    int                checks = 0;
    int                seed = 32'h6469;
    int                m_locked, m_frozen, m_enabled, m_max, m_cnt, m_exh, m_prep;
    logic [15:0][15:0] pw, user_pw, master_pw;
    logic [7:0]        unl_codes [4] = '{8'h20, 8'hc4, 8'hec, 8'he0};
    logic [7:0]        lck_codes [14] = '{8'h20, 8'h21, 8'h30, 8'h38, 8'h3c, 8'h40, 8'hc0,
                                          8'hcd, 8'hf6, 8'hf5, 8'hf1, 8'hec, 8'he0, 8'hf3};
    logic [7:0]        frz_codes [7] = '{8'hf3, 8'hf1, 8'hf6, 8'hf4, 8'hf2, 8'h20, 8'hf5};

    always #10 clk_in = ~clk_in;

    storage_security_lock_fsm uut (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr),
        .wr_data_in(wr_data), .wr_in(wr), .rd_in(rd), .factory_init_in(factory_init_in),
        .rd_data_out(rd_data), .cmd_done_out(cmd_done), .err_out(err),
        .command_aborted_flag_out(aborted), .exec_out(exec), .exec_code_out(exec_code),
        .erase_media_out(erase), .locked_out(locked), .frozen_out(frozen),
        .attempts_exhausted_flag_out(exhausted));
    host_bus host (.clk_in(clk_in), .rd_data_in(rd_data), .addr_out(addr),
        .wr_data_out(wr_data), .wr_out(wr), .rd_out(rd));

    task automatic end_of_test;
        if (err_total == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic new_pw;
        logic [31:0] r;
        for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            pw[i] = r[15:0];
        end
    endtask
    task automatic do_reset;
        reset_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        reset_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        m_frozen = 0;
        m_exh = 0;
        m_cnt = 5;
        m_prep = 0;
        m_locked = m_enabled;
    endtask
    task automatic check_levels;
        logic [15:0] st;
        logic [15:0] id;
        host.read_reg(`REG_STATUS, st);
        host.read_reg(`REG_IDENT128, id);
        chk({st[10:8], st[4]}, {3'(m_cnt), 1'(m_enabled)}, "status");
        chk(id[4:0], {1'(m_exh), 1'(m_frozen), 1'(m_locked), 1'(m_enabled), 1'b1}, "ident");
        chk({locked, frozen, exhausted}, {1'(m_locked), 1'(m_frozen), 1'(m_exh)}, "levels");
    endtask
    task automatic run_cmd(input logic [7:0] code, input logic [1:0] ctrl);
        logic tm, mt, ab, ex, er, s_ex, s_er;
        int n;
        tm = ctrl[0];
        mt = tm ? (pw === master_pw) : (pw === user_pw);
        {ab, ex, er, s_ex, s_er} = 5'h00;
        if (code inside {`CMD_SET_PWD, `CMD_UNLOCK, `CMD_ERASE_UNIT, `CMD_DISABLE_PWD}) begin
            for (int i = 0; i < 16; i++) begin
                host.write_reg(5'(i), pw[i]);
            end
        end
        host.write_reg(`REG_CTRL, {14'h0, ctrl});
        if (code == `CMD_FREEZE) begin
            host.freeze_lock();
        end else begin
            host.write_reg(`REG_CMD, {8'h00, code});
        end
        for (n = 0; n < 40; n++) begin
            @(posedge clk_in);
            s_ex |= exec;
            s_er |= erase;
            if (cmd_done === 1'b1) begin
                break;
            end
        end
        if (n == 40) begin
            err_total++;
            $display("MISMATCH %0t no completion for %h", $time, code);
            end_of_test();
        end
        case (code)
            `CMD_SET_PWD: begin
                ab = m_locked || m_frozen;
                if (!ab && tm) begin
                    master_pw = pw;
                end else if (!ab) begin
                    user_pw = pw;
                    m_enabled = 1;
                    m_max = ctrl[1];
                end
            end
            `CMD_UNLOCK: begin
                ab = m_frozen || m_exh || !mt || (tm && m_max);
                if (!m_frozen && !m_exh && ab) begin
                    m_cnt--;
                end else if (!ab) begin
                    m_locked = 0;
                end
                m_exh = (m_cnt == 0);
            end
            `CMD_ERASE_PREP: ab = 0;
            `CMD_ERASE_UNIT: begin
                ab = m_frozen || m_exh || !m_prep || !mt;
                er = !ab;
                if (!ab) begin
                    m_locked = 0;
                    m_enabled = 0;
                end
            end
            `CMD_FREEZE: begin
                ab = m_locked;
                m_frozen = m_frozen || !ab;
            end
            `CMD_DISABLE_PWD: begin
                ab = m_locked || m_frozen || !mt || (tm && m_max);
                m_enabled = ab ? m_enabled : 0;
            end
            default: begin
                ab = m_locked && (code inside {[8'h20:8'h23], [8'h30:8'h33], 8'h38, 8'h3c,
                    8'h40, 8'h41, 8'h50, 8'hc0, 8'hc4, 8'hc5, 8'hcd});
                ex = !ab;
            end
        endcase
        m_prep = (code == `CMD_ERASE_PREP);
        chk({err, aborted}, {ab, ab}, "error and aborted");
        chk({s_ex, s_er}, {ex, er}, "exec or erase");
        if (ex) begin
            chk(exec_code, code, "exec code");
        end
        check_levels();
    endtask

    initial begin
        do_reset();
        factory_init_in <= 1'b1;
        repeat (18) @(posedge clk_in);
        factory_init_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        master_pw = {16{16'h5a3c}};
        m_enabled = 0;
        m_max = 0;
        do_reset();
        check_levels();
        pw = master_pw;
        run_cmd(`CMD_UNLOCK, 2'b01);
        foreach (unl_codes[i]) run_cmd(unl_codes[i], 2'b00);
        new_pw();
        run_cmd(`CMD_SET_PWD, 2'b01);
        new_pw();
        run_cmd(`CMD_SET_PWD, 2'b00);
        do_reset();
        check_levels();
        foreach (lck_codes[i]) run_cmd(lck_codes[i], 2'b00);
        new_pw();
        run_cmd(`CMD_UNLOCK, 2'b00);
        run_cmd(`CMD_UNLOCK, 2'b01);
        pw = master_pw;
        run_cmd(`CMD_UNLOCK, 2'b01);
        run_cmd(`CMD_FREEZE, 2'b00);
        foreach (frz_codes[i]) run_cmd(frz_codes[i], 2'b01);
        do_reset();
        check_levels();
        new_pw();
        repeat (5) run_cmd(`CMD_UNLOCK, 2'b00);
        pw = user_pw;
        run_cmd(`CMD_UNLOCK, 2'b00);
        pw = master_pw;
        run_cmd(`CMD_ERASE_PREP, 2'b01);
        run_cmd(`CMD_ERASE_UNIT, 2'b01);
        do_reset();
        check_levels();
        pw = user_pw;
        run_cmd(`CMD_UNLOCK, 2'b00);
        run_cmd(`CMD_DISABLE_PWD, 2'b00);
        new_pw();
        run_cmd(`CMD_SET_PWD, 2'b10);
        do_reset();
        pw = master_pw;
        run_cmd(`CMD_UNLOCK, 2'b01);
        run_cmd(`CMD_ERASE_UNIT, 2'b01);
        new_pw();
        run_cmd(`CMD_ERASE_PREP, 2'b01);
        run_cmd(`CMD_ERASE_UNIT, 2'b01);
        pw = master_pw;
        run_cmd(`CMD_ERASE_PREP, 2'b01);
        run_cmd(`CMD_ERASE_UNIT, 2'b01);
        end_of_test();
    end
endmodule
`default_nettype wire
